// file: ec_host_port_smbus_status.sv
// embedded controller host byte port with smbus host status register
// How it works
// - read: irq after command, none address, on data
// - write: irq on every input-full clear
// - query: irq only when reply lands
// - burst enter: irq when acknowledge lands
// - burst exit: irq when byte consumed
// - command byte first, then defined data bytes
// - input-full set within one microsecond
// - input-full clears when controller reads byte
// - output-full sets on load, clears on read
// - smbus registers at consecutive addresses
// - filtered commands refused with 12h/17h
// - protocol write clears status, keeps alarm
// - result code written before protocol clears
// - query event only after protocol cleared
// - bit7 done without error, bit5 reserved
// - bit6 set on alarm message
// - codes 00h 07h 10h 11h
// - codes 12h 13h 17h 18h
// - codes 19h 1Ah, others never produced
// - burst grant: status bit, 90h, output-full
// - query reply zero means no event
// - interrupt is a pulse, edge event
// - protocol write of 01h to 0Ch starts smbus transaction
`timescale 1ns/1ns
module ec_host_port_smbus_status
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // host port strobes, from pins
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic host_cmd_sel,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic [7:0] port_status,
  output logic system_control_interrupt,
  // controller event source
  input wire logic event_pending,
  input wire logic [7:0] event_code,
  // controller memory access for write commands
  output logic mem_wr,
  output logic [7:0] mem_addr,
  output logic [7:0] mem_wdata,
  // smbus engine side
  output logic smb_start,
  output logic [7:0] smb_protocol,
  input wire logic smb_finish,
  input wire logic [4:0] smb_code,
  input wire logic smb_alarm,
  output logic smb_query_event
);
  typedef enum {ST_IDLE, ST_RD_ADDR, ST_WR_ADDR, ST_WR_DATA} port_state_type;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] wr_sync_r;
  logic [2:0] rd_sync_r;
  logic wr_lvl_r;
  logic rd_lvl_r;
  logic wr_pulse;
  logic rd_pulse;
  logic cmd_sel_r;
  logic [7:0] wdata_r;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      wr_sync_r <= 3'b000;
      rd_sync_r <= 3'b000;
      wr_lvl_r <= 1'b0;
      rd_lvl_r <= 1'b0;
    end
    else
    begin
      wr_sync_r <= {wr_sync_r[1:0], host_wr};
      rd_sync_r <= {rd_sync_r[1:0], host_rd};
      if (wr_sync_r[2] == wr_sync_r[1])
      begin
        wr_lvl_r <= wr_sync_r[2];
      end
      if (rd_sync_r[2] == rd_sync_r[1])
      begin
        rd_lvl_r <= rd_sync_r[2];
      end
    end
  end

  assign wr_pulse = (wr_sync_r[2] == wr_sync_r[1]) && wr_sync_r[2] && !wr_lvl_r;
  assign rd_pulse = (rd_sync_r[2] == rd_sync_r[1]) && rd_sync_r[2] && !rd_lvl_r;

  // data and select are stable around the strobe
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cmd_sel_r <= 1'b0;
      wdata_r <= 8'h00;
    end
    else
    begin
      // load one edge ahead of the strobe pulse, so the pulse sees this byte
      if (wr_sync_r[1] || rd_sync_r[1])
      begin
        cmd_sel_r <= host_cmd_sel;
      end
      if (wr_sync_r[1])
      begin
        wdata_r <= host_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // input buffer
  // ----------------------------------------------------------------
  logic in_full_r;
  logic in_is_cmd_r;
  logic [7:0] in_byte_r;
  logic consume;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      in_full_r <= 1'b0;
      in_is_cmd_r <= 1'b0;
      in_byte_r <= 8'h00;
    end
    else if (wr_pulse)
    begin
      in_full_r <= 1'b1;
      in_is_cmd_r <= cmd_sel_r;
      in_byte_r <= wdata_r;
    end
    else if (consume)
    begin
      in_full_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // output buffer fed through the skid buffer
  // ----------------------------------------------------------------
  byte_stream_if ret_in ();
  byte_stream_if ret_out ();
  logic ret_valid_r;
  logic [7:0] ret_data_r;
  logic out_full_r;
  logic [7:0] out_byte_r;
  logic out_load;

  assign ret_in.valid = ret_valid_r;
  assign ret_in.data = ret_data_r;
  assign ret_out.ready = !out_full_r;
  assign out_load = ret_out.valid && !out_full_r;

  byte_buffer2 u_buf
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_s(ret_in),
    .out_s(ret_out)
  );

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      out_full_r <= 1'b0;
      out_byte_r <= 8'h00;
    end
    else if (out_load)
    begin
      out_full_r <= 1'b1;
      out_byte_r <= ret_out.data;
    end
    else if (rd_pulse && !cmd_sel_r)
    begin
      out_full_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  port_state_type state_r;
  logic burst_r;
  logic [7:0] addr_r;
  logic irq_on_consume;
  logic smb_access;
  logic [7:0] rd_value;
  logic [7:0] prot_r;
  logic [7:0] sts_r;

  // the controller takes an input byte only when the return path has room
  assign consume = in_full_r && ret_in.ready && !ret_valid_r;
  assign smb_access = (addr_r >= ec_port_pkg::SMB_BASE) && (addr_r <= ec_port_pkg::OFS_DATA1);

  always_comb
  begin
    rd_value = 8'h00;
    unique case (in_byte_r)
      ec_port_pkg::OFS_PROTOCOL: rd_value = prot_r;
      ec_port_pkg::OFS_STATUS: rd_value = sts_r;
      default: rd_value = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      burst_r <= 1'b0;
      addr_r <= 8'h00;
      ret_valid_r <= 1'b0;
      ret_data_r <= 8'h00;
      mem_wr <= 1'b0;
      mem_addr <= 8'h00;
      mem_wdata <= 8'h00;
    end
    else
    begin
      mem_wr <= 1'b0;
      if (ret_valid_r && ret_in.ready)
      begin
        ret_valid_r <= 1'b0;
      end
      if (consume)
      begin
        // a command byte always restarts the exchange
        if (in_is_cmd_r)
        begin
          state_r <= ST_IDLE;
          unique case (in_byte_r)
            ec_port_pkg::CMD_READ: state_r <= ST_RD_ADDR;
            ec_port_pkg::CMD_WRITE: state_r <= ST_WR_ADDR;
            ec_port_pkg::EVENT_QUERY_COMMAND:
            begin
              ret_valid_r <= 1'b1;
              ret_data_r <= event_pending ? event_code : 8'h00;
            end
            ec_port_pkg::BURST_ENTER_COMMAND:
            begin
              burst_r <= 1'b1;
              ret_valid_r <= 1'b1;
              ret_data_r <= ec_port_pkg::BURST_ACK;
            end
            ec_port_pkg::BURST_EXIT_COMMAND: burst_r <= 1'b0;
            default: state_r <= ST_IDLE;
          endcase
        end
        else
        begin
          unique case (state_r)
            ST_RD_ADDR:
            begin
              ret_valid_r <= 1'b1;
              ret_data_r <= rd_value;
              state_r <= ST_IDLE;
            end
            ST_WR_ADDR:
            begin
              addr_r <= in_byte_r;
              state_r <= ST_WR_DATA;
            end
            ST_WR_DATA:
            begin
              mem_wr <= 1'b1;
              mem_addr <= addr_r;
              mem_wdata <= in_byte_r;
              state_r <= ST_IDLE;
            end
            ST_IDLE: state_r <= ST_IDLE;
          endcase
        end
      end
    end
  end

  // which consumed bytes interrupt on input-full clearing
  always_comb
  begin
    irq_on_consume = 1'b0;
    if (in_is_cmd_r)
    begin
      irq_on_consume = (in_byte_r != ec_port_pkg::EVENT_QUERY_COMMAND) &&
                       (in_byte_r != ec_port_pkg::BURST_ENTER_COMMAND);
    end
    else
    begin
      irq_on_consume = (state_r == ST_WR_ADDR) || (state_r == ST_WR_DATA);
    end
  end

  // ----------------------------------------------------------------
  // smbus protocol and status registers
  // ----------------------------------------------------------------
  logic prot_wr;
  logic sts_wr;
  logic finish_pending_r;
  logic query_arm_r;

  assign prot_wr = mem_wr && smb_access && (mem_addr == ec_port_pkg::OFS_PROTOCOL);
  assign sts_wr = mem_wr && smb_access && (mem_addr == ec_port_pkg::OFS_STATUS);
  assign smb_protocol = prot_r;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      prot_r <= ec_port_pkg::PROTO_IDLE;
      sts_r <= ec_port_pkg::STS_RESET;
      finish_pending_r <= 1'b0;
      query_arm_r <= 1'b0;
      smb_start <= 1'b0;
      smb_query_event <= 1'b0;
    end
    else
    begin
      smb_start <= 1'b0;
      query_arm_r <= 1'b0;
      if (prot_wr)
      begin
        prot_r <= mem_wdata;
        sts_r <= {1'b0, sts_r[ec_port_pkg::STS_ALARM], 6'b00_0000};
        smb_start <= (mem_wdata != ec_port_pkg::PROTO_IDLE);
        if (mem_wdata > ec_port_pkg::PROTO_MAX)
        begin
          // unsupported protocol answered locally
          sts_r <= {1'b0, sts_r[ec_port_pkg::STS_ALARM], 1'b0, ec_port_pkg::CODE_BAD_PROTOCOL};
          finish_pending_r <= 1'b1;
          smb_start <= 1'b0;
        end
      end
      else if (smb_finish && prot_r != ec_port_pkg::PROTO_IDLE)
      begin
        // code first, bit5 reserved as zero
        sts_r <= {(smb_code == ec_port_pkg::CODE_OK), sts_r[ec_port_pkg::STS_ALARM] | smb_alarm, 1'b0,
                  smb_code};
        finish_pending_r <= 1'b1;
      end
      else if (finish_pending_r)
      begin
        prot_r <= ec_port_pkg::PROTO_IDLE;
        finish_pending_r <= 1'b0;
        query_arm_r <= 1'b1;
      end
      else if (sts_wr && mem_wdata == 8'h00)
      begin
        sts_r <= ec_port_pkg::STS_RESET;
      end
      // a new alarm wins over any clear in the same cycle
      if (smb_alarm)
      begin
        sts_r[ec_port_pkg::STS_ALARM] <= 1'b1;
      end
      // event goes out one cycle after the protocol register reads idle
      smb_query_event <= query_arm_r;
    end
  end

  // ----------------------------------------------------------------
  // interrupt pulse and host readback
  // ----------------------------------------------------------------
  logic [2:0] pulse_cnt_r;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pulse_cnt_r <= 3'd0;
      system_control_interrupt <= 1'b0;
    end
    else
    begin
      if ((consume && irq_on_consume) || out_load)
      begin
        pulse_cnt_r <= 3'(ec_port_pkg::IRQ_PULSE_CYC);
      end
      else if (pulse_cnt_r != 3'd0)
      begin
        pulse_cnt_r <= pulse_cnt_r - 3'd1;
      end
      system_control_interrupt <= (pulse_cnt_r != 3'd0);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      host_rdata <= 8'h00;
      port_status <= 8'h00;
    end
    else
    begin
      host_rdata <= out_byte_r;
      port_status <= {2'b00, event_pending, burst_r, in_is_cmd_r, 1'b0, in_full_r, out_full_r};
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_in_full_fast;
    @(posedge clk_sys) disable iff (rst) wr_pulse |=> in_full_r;
  endproperty
  a_in_full_fast: assert property (p_in_full_fast) else $error("input-full not set");

  property p_consume_clears;
    @(posedge clk_sys) disable iff (rst) (consume && !wr_pulse) |=> !in_full_r;
  endproperty
  a_consume_clears: assert property (p_consume_clears) else $error("input-full not cleared");

  property p_out_full_set;
    @(posedge clk_sys) disable iff (rst) out_load |=> out_full_r && out_byte_r == $past(ret_out.data);
  endproperty
  a_out_full_set: assert property (p_out_full_set) else $error("output-full not set");

  property p_query_no_irq;
    @(posedge clk_sys) disable iff (rst)
      (consume && in_is_cmd_r && in_byte_r == ec_port_pkg::EVENT_QUERY_COMMAND && pulse_cnt_r == 3'd0
       && !out_load) |=> pulse_cnt_r == 3'd0;
  endproperty
  a_query_no_irq: assert property (p_query_no_irq) else $error("query irq early");

  property p_burst_ack;
    @(posedge clk_sys) disable iff (rst)
      (consume && in_is_cmd_r && in_byte_r == ec_port_pkg::BURST_ENTER_COMMAND) |=>
      burst_r && ret_data_r == ec_port_pkg::BURST_ACK;
  endproperty
  a_burst_ack: assert property (p_burst_ack) else $error("burst ack missing");

  property p_proto_clear_sts;
    @(posedge clk_sys) disable iff (rst)
      (prot_wr && !smb_alarm) |=> sts_r[5:0] inside {6'h00, 6'h19} && !sts_r[ec_port_pkg::STS_DONE]
      && sts_r[ec_port_pkg::STS_ALARM] == $past(sts_r[ec_port_pkg::STS_ALARM]);
  endproperty
  a_proto_clear_sts: assert property (p_proto_clear_sts) else $error("status not cleared");

  sequence s_code_written;
    finish_pending_r && prot_r != ec_port_pkg::PROTO_IDLE;
  endsequence
  sequence s_proto_cleared;
    prot_r == ec_port_pkg::PROTO_IDLE ##1 smb_query_event;
  endsequence
  property p_finish_order;
    @(posedge clk_sys) disable iff (rst) (s_code_written and !prot_wr) |=> s_proto_cleared;
  endproperty
  a_finish_order: assert property (p_finish_order) else $error("finish order wrong");

  property p_event_after_clear;
    @(posedge clk_sys) disable iff (rst)
      smb_query_event |-> $past(finish_pending_r, 2) && $past(prot_r) == ec_port_pkg::PROTO_IDLE;
  endproperty
  a_event_after_clear: assert property (p_event_after_clear) else $error("event too early");

  property p_res_bit;
    @(posedge clk_sys) disable iff (rst) !sts_r[5];
  endproperty
  a_res_bit: assert property (p_res_bit) else $error("reserved bit set");

  property p_irq_pulse;
    @(posedge clk_sys) disable iff (rst) $rose(system_control_interrupt) |-> ##[1:8] !system_control_interrupt;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq not a pulse");
endmodule

// file: ec_port_pkg.sv
// shared constants for the embedded controller host port
package ec_port_pkg;
  // port command bytes
  localparam logic [7:0] CMD_READ = 8'h80;
  localparam logic [7:0] CMD_WRITE = 8'h81;
  localparam logic [7:0] BURST_ENTER_COMMAND = 8'h82;
  localparam logic [7:0] BURST_EXIT_COMMAND = 8'h83;
  localparam logic [7:0] EVENT_QUERY_COMMAND = 8'h84;
  localparam logic [7:0] BURST_ACK = 8'h90;
  // port status bits
  localparam int STAT_OUT_FULL = 0;
  localparam int STAT_IN_FULL = 1;
  localparam int STAT_CMD = 3;
  localparam int STAT_BURST = 4;
  localparam int STAT_EVT = 5;
  // input-full flag must rise within this time of a host write
  localparam int IN_FULL_MAX_NS = 1000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int IN_FULL_MAX_CYC = IN_FULL_MAX_NS / CLK_PERIOD_NS;
  // interrupt pulse length
  localparam int IRQ_PULSE_CYC = 4;
  // smbus block, consecutive offsets inside controller space
  localparam logic [7:0] SMB_BASE = 8'h00;
  localparam logic [7:0] OFS_PROTOCOL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h01;
  localparam logic [7:0] OFS_ADDR = 8'h02;
  localparam logic [7:0] OFS_CMD = 8'h03;
  localparam logic [7:0] OFS_DATA0 = 8'h04;
  localparam logic [7:0] OFS_DATA1 = 8'h05;
  // status layout
  localparam int STS_DONE = 7;
  localparam int STS_ALARM = 6;
  localparam int STS_CODE_HI = 4;
  localparam logic [7:0] STS_RESET = 8'h00;
  // status codes
  localparam logic [4:0] CODE_OK = 5'h00;
  localparam logic [4:0] CODE_UNKNOWN_FAIL = 5'h07;
  localparam logic [4:0] CODE_ADDR_NACK = 5'h10;
  localparam logic [4:0] CODE_DEV_ERROR = 5'h11;
  localparam logic [4:0] CODE_CMD_DENIED = 5'h12;
  localparam logic [4:0] CODE_HOST_ERROR = 5'h13;
  localparam logic [4:0] CODE_DEV_DENIED = 5'h17;
  localparam logic [4:0] CODE_TIMEOUT = 5'h18;
  localparam logic [4:0] CODE_BAD_PROTOCOL = 5'h19;
  localparam logic [4:0] CODE_BUSY = 5'h1A;
  localparam logic [7:0] PROTO_IDLE = 8'h00;
  localparam logic [7:0] PROTO_MAX = 8'h0C;
endpackage

// file: byte_stream_if.sv
// byte stream between port logic and the output buffer
`timescale 1ns/1ns
interface byte_stream_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: byte_buffer2.sv
// two-entry skid buffer for returned bytes
`timescale 1ns/1ns
module byte_buffer2
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // streams
  byte_stream_if.snk in_s,
  byte_stream_if.src out_s
);
  logic [7:0] mem_r [2];
  logic wptr_r;
  logic rptr_r;
  logic [1:0] cnt_r;
  logic push;
  logic pop;

  assign in_s.ready = (cnt_r != 2'd2);
  assign out_s.valid = (cnt_r != 2'd0);
  assign out_s.data = mem_r[rptr_r];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem_r[wptr_r] <= in_s.data;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      wptr_r <= 1'b0;
      rptr_r <= 1'b0;
      cnt_r <= 2'd0;
    end
    else
    begin
      if (push)
      begin
        wptr_r <= ~wptr_r;
      end
      if (pop)
      begin
        rptr_r <= ~rptr_r;
      end
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// file: host_model.sv
// host processor model driving the controller byte port
`timescale 1ns/1ns
module host_model
(
  // clock
  input wire logic clk_sys,
  // port pins
  output logic host_wr,
  output logic host_rd,
  output logic host_cmd_sel,
  output logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  input wire logic [7:0] port_status,
  // wait limit ran out
  output logic timed_out
);
  int lat_max;

  initial
  begin
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_cmd_sel = 1'b0;
    host_wdata = 8'h00;
    timed_out = 1'b0;
    lat_max = 0;
  end

  // waits at falling edges for a status bit, bounded
  task automatic wait_bit(input int pos, input logic lvl, output int n);
    n = 0;
    while (port_status[pos] !== lvl && n < 200)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 200)
      timed_out = 1'b1;
  endtask

  // one byte to command or data port; the port is owned by default, no lock
  task automatic put(input logic cmd, input logic [7:0] b);
    int n;
    wait_bit(ec_port_pkg::STAT_IN_FULL, 1'b0, n);
    repeat (4) @(posedge clk_sys);
    host_cmd_sel <= cmd;
    host_wdata <= b;
    host_wr <= 1'b1;
    @(negedge clk_sys);
    wait_bit(ec_port_pkg::STAT_IN_FULL, 1'b1, n);
    if (n + 1 > lat_max)
      lat_max = n + 1;
    @(posedge clk_sys);
    host_wr <= 1'b0;
    // a released bus no longer shows the byte
    host_wdata <= ~b;
    wait_bit(ec_port_pkg::STAT_IN_FULL, 1'b0, n);
  endtask

  // one byte from the data port, held read until output-full drops
  task automatic get(output logic [7:0] b);
    int n;
    wait_bit(ec_port_pkg::STAT_OUT_FULL, 1'b1, n);
    repeat (2) @(negedge clk_sys);
    b = host_rdata;
    @(posedge clk_sys);
    host_cmd_sel <= 1'b0;
    host_rd <= 1'b1;
    @(negedge clk_sys);
    wait_bit(ec_port_pkg::STAT_OUT_FULL, 1'b0, n);
    @(posedge clk_sys);
    host_rd <= 1'b0;
  endtask
endmodule

// file: ec_host_port_smbus_status_test.sv
// self-checking testbench for the controller host port
`timescale 1ns/1ns
module ec_host_port_smbus_status_test;
  localparam logic [4:0] CODES [10] = '{5'h00, 5'h07, 5'h10, 5'h11, 5'h12, 5'h13, 5'h17, 5'h18, 5'h19, 5'h1A};
  logic clk_sys;
  logic rst;
  logic host_wr;
  logic host_rd;
  logic host_cmd_sel;
  logic [7:0] host_wdata;
  logic [7:0] host_rdata;
  logic [7:0] port_status;
  logic system_control_interrupt;
  logic event_pending;
  logic [7:0] event_code;
  logic mem_wr;
  logic [7:0] mem_addr;
  logic [7:0] mem_wdata;
  logic smb_start;
  logic smb_finish;
  logic [4:0] smb_code;
  logic smb_alarm;
  logic smb_query_event;
  logic host_timed_out;
  logic irq_q;
  logic [4:0] code_q;
  logic [7:0] wa;
  logic [7:0] wd;
  logic [7:0] b;
  int irq_n;
  int qev_n;
  int start_n;
  int fin_cnt;
  int i0;
  int q0;
  int s0;
  int miscompares;
  int cmp_count;

  // ----------------------------------------
  // clock, design and host
  // ----------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  ec_host_port_smbus_status dut (.clk_sys(clk_sys), .rst(rst), .host_wr(host_wr), .host_rd(host_rd),
    .host_cmd_sel(host_cmd_sel), .host_wdata(host_wdata), .host_rdata(host_rdata), .port_status(port_status),
    .system_control_interrupt(system_control_interrupt), .event_pending(event_pending), .event_code(event_code),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .smb_start(smb_start), .smb_protocol(),
    .smb_finish(smb_finish), .smb_code(smb_code), .smb_alarm(smb_alarm), .smb_query_event(smb_query_event));

  host_model host (.clk_sys(clk_sys), .host_wr(host_wr), .host_rd(host_rd), .host_cmd_sel(host_cmd_sel),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .port_status(port_status), .timed_out(host_timed_out));

  // ----------------------------------------
  // monitors and smbus engine stand-in
  // ----------------------------------------
  always @(posedge clk_sys)
  begin
    irq_q <= system_control_interrupt;
    if (system_control_interrupt === 1'b1 && irq_q === 1'b0)
      irq_n <= irq_n + 1;
    if (smb_query_event === 1'b1)
      qev_n <= qev_n + 1;
    if (mem_wr === 1'b1)
    begin
      wa <= mem_addr;
      wd <= mem_wdata;
    end
    smb_finish <= 1'b0;
    if (fin_cnt == 1)
    begin
      smb_finish <= 1'b1;
      smb_code <= code_q;
    end
    if (fin_cnt > 0)
      fin_cnt <= fin_cnt - 1;
    if (smb_start === 1'b1)
    begin
      start_n <= start_n + 1;
      fin_cnt <= 6;
    end
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic mark();
    i0 = irq_n;
    q0 = qev_n;
    s0 = start_n;
  endtask

  task automatic cmd_wr(input logic [7:0] a, input logic [7:0] d);
    host.put(1'b1, ec_port_pkg::CMD_WRITE);
    host.put(1'b0, a);
    host.put(1'b0, d);
    repeat (20) @(posedge clk_sys);
  endtask

  task automatic cmd_rd(input logic [7:0] a, output logic [7:0] d);
    host.put(1'b1, ec_port_pkg::CMD_READ);
    host.put(1'b0, a);
    host.get(d);
    repeat (12) @(posedge clk_sys);
  endtask

  task automatic results();
    chk({7'h00, host_timed_out}, 8'h00);
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_write_read();
    mark();
    cmd_wr(8'h42, 8'hA5);
    chk(8'(irq_n - i0), 8'h03);
    chk(wa, 8'h42);
    chk(wd, 8'hA5);
    chk(8'(host.lat_max <= ec_port_pkg::IN_FULL_MAX_CYC), 8'h01);
    mark();
    cmd_rd(ec_port_pkg::OFS_STATUS, b);
    chk(b, ec_port_pkg::STS_RESET);
    chk(8'(irq_n - i0), 8'h02);
    chk({7'h00, port_status[ec_port_pkg::STAT_OUT_FULL]}, 8'h00);
  endtask

  task automatic t_query(input logic ev, input logic [7:0] code);
    event_pending <= ev;
    event_code <= code;
    mark();
    host.put(1'b1, ec_port_pkg::EVENT_QUERY_COMMAND);
    host.get(b);
    event_pending <= 1'b0;
    repeat (12) @(posedge clk_sys);
    chk(b, ev ? code : 8'h00);
    chk(8'(irq_n - i0), 8'h01);
  endtask

  task automatic t_burst();
    mark();
    host.put(1'b1, ec_port_pkg::BURST_ENTER_COMMAND);
    host.get(b);
    repeat (12) @(posedge clk_sys);
    chk(b, ec_port_pkg::BURST_ACK);
    chk({7'h00, port_status[ec_port_pkg::STAT_BURST]}, 8'h01);
    chk(8'(irq_n - i0), 8'h01);
    mark();
    host.put(1'b1, ec_port_pkg::BURST_EXIT_COMMAND);
    repeat (12) @(posedge clk_sys);
    chk(8'(irq_n - i0), 8'h01);
    chk({7'h00, port_status[ec_port_pkg::STAT_BURST]}, 8'h00);
  endtask

  task automatic t_codes();
    foreach (CODES[k])
    begin
      code_q <= CODES[k];
      mark();
      cmd_wr(ec_port_pkg::OFS_PROTOCOL, 8'h07);
      chk(8'(start_n - s0), 8'h01);
      chk(8'(qev_n - q0), 8'h01);
      cmd_rd(ec_port_pkg::OFS_STATUS, b);
      chk(b, {CODES[k] == 5'h00, 2'b00, CODES[k]});
      cmd_rd(ec_port_pkg::OFS_PROTOCOL, b);
      chk(b, ec_port_pkg::PROTO_IDLE);
    end
  endtask

  task automatic t_refuse_alarm();
    mark();
    cmd_wr(ec_port_pkg::OFS_PROTOCOL, 8'h0D);
    chk(8'(start_n - s0), 8'h00);
    cmd_rd(ec_port_pkg::OFS_STATUS, b);
    chk(b, 8'h19);
    @(posedge clk_sys);
    smb_alarm <= 1'b1;
    @(posedge clk_sys);
    smb_alarm <= 1'b0;
    cmd_rd(ec_port_pkg::OFS_STATUS, b);
    chk(b, 8'h59);
    code_q <= 5'h00;
    cmd_wr(ec_port_pkg::OFS_PROTOCOL, 8'h07);
    cmd_rd(ec_port_pkg::OFS_STATUS, b);
    chk(b, 8'hC0);
    cmd_wr(ec_port_pkg::OFS_STATUS, 8'h00);
    cmd_rd(ec_port_pkg::OFS_STATUS, b);
    chk(b, 8'h00);
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    rst = 1'b1;
    event_pending = 1'b0;
    event_code = 8'h00;
    smb_finish = 1'b0;
    smb_code = 5'h00;
    smb_alarm = 1'b0;
    code_q = 5'h00;
    irq_q = 1'b0;
    irq_n = 0;
    qev_n = 0;
    start_n = 0;
    fin_cnt = 0;
    miscompares = 0;
    cmp_count = 0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(negedge clk_sys);
    chk(port_status & 8'h03, 8'h00);
    chk({7'h00, system_control_interrupt}, 8'h00);
    t_write_read();
    t_query(1'b1, 8'h5C);
    t_query(1'b0, 8'h5C);
    t_burst();
    t_codes();
    t_refuse_alarm();
    results();
  end

  initial
  begin
    repeat (60000) @(posedge clk_sys);
    miscompares++;
    results();
  end
endmodule
